/* rtl/tmr_cfg.svh */
// Offsets, field positions, reset values and timing counts for the 8-bit timer.
// Assumes nothing beyond being included by name.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_ADDR_COUNT 8'h01
`define TMR_OPT_RESET 8'hFF
`define TMR_DIR_RESET 4'hF
`define TMR_BIT_WAKE 7
`define TMR_BIT_PULL 6
`define TMR_BIT_SRC 5
`define TMR_BIT_EDGE 4
`define TMR_BIT_PSA 3
`define TMR_RATE_HI 2
`define TMR_RATE_LO 0
`define TMR_PIN_COUNT 2
`define TMR_INHIBIT_CYC 2'h2
`define TMR_CLK_NS 10
`define TMR_TOSC_NS 10
`define TMR_EXT_DLY_MIN_TOSC 3
`define TMR_EXT_DLY_MAX_TOSC 7
`define TMR_EXT_DLY_MIN_CYC ((`TMR_EXT_DLY_MIN_TOSC * `TMR_TOSC_NS + `TMR_CLK_NS - 1) / `TMR_CLK_NS)
`define TMR_EXT_DLY_MAX_CYC ((`TMR_EXT_DLY_MAX_TOSC * `TMR_TOSC_NS) / `TMR_CLK_NS)
`endif

/* rtl/tmr_pkg.sv */
// Types shared by the 8-bit timer and its users.
// Assumes the core drives all strobes on the same clock.
package tmr_pkg;
  typedef logic [7:0] tmr_byte_t;
  typedef logic [3:0] tmr_dir_t;
  typedef logic [2:0] tmr_pins3_t;
  // Internal phases, Gray coded along the cycle
  typedef enum logic [1:0] {
    TMR_PH_Q1 = 2'b00,
    TMR_PH_Q2 = 2'b01,
    TMR_PH_Q3 = 2'b11,
    TMR_PH_Q4 = 2'b10
  } tmr_phase_t;
endpackage

/* rtl/tmr_timer8.sv */
// 8-bit timer/counter with a prescaler shared with the watchdog.
// Assumes clk is the oscillator (four clocks per instruction cycle), that the
// core pulses its strobes for one clock, and that the watchdog ticks arrive
// from the watchdog's own oscillator as a slow level toggle.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_timer8 #(
  parameter int PRE_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data file write from the core
  input wire logic fileWrEn,
  input wire tmr_pkg::tmr_byte_t fileAddr,
  input wire tmr_pkg::tmr_byte_t fileWrData,
  // Dedicated loads from the working register
  input wire logic optLoad,
  input wire logic dirLoad,
  input wire tmr_pkg::tmr_byte_t workReg,
  // Watchdog side
  input wire logic wdtClearOp,
  input wire logic wdtTickIn,
  output logic wdtPostTick,
  // External count pin
  input wire logic extCountIn,
  // Timer and pin control outputs
  output tmr_pkg::tmr_byte_t timerValue,
  output logic instrTick,
  output tmr_pkg::tmr_dir_t pinDirEff,
  output tmr_pkg::tmr_pins3_t wakeEnable,
  output tmr_pkg::tmr_pins3_t pullupEnable
);
  import tmr_pkg::*;

  // Elaboration check on the prescaler width
  if (PRE_W != 8) begin : g_bad_width
    $error("tmr_timer8: PRE_W must be 8");
  end

  tmr_phase_t phase_ff;
  tmr_phase_t nxt_phase;
  tmr_byte_t timerCount_ff;
  tmr_byte_t nxt_timerCount;
  tmr_byte_t optWord_ff;
  tmr_dir_t dirCtl_ff;
  logic [PRE_W-1:0] prescale_ff;
  logic [PRE_W-1:0] nxt_prescale;
  logic [1:0] inhibit_ff;
  logic [1:0] nxt_inhibit;
  logic extSync1_ff;
  logic extSync2_ff;
  logic pinSample_ff;
  logic extEdge_ff;
  logic wdtSync1_ff;
  logic wdtSync2_ff;
  logic wdtLast_ff;

  // Low bits that must be ones before the prescaler passes a tick
  function automatic logic [PRE_W-1:0] rateMask(input logic [2:0] rate, input logic forWdt);
    logic [3:0] shiftAmt;
    shiftAmt = {1'b0, rate} + {3'h0, ~forWdt};
    rateMask = ~({PRE_W{1'b1}} << shiftAmt);
  endfunction

  // Control word fields
  wire logic wakeDisable = optWord_ff[`TMR_BIT_WAKE];
  wire logic pullDisable = optWord_ff[`TMR_BIT_PULL];
  wire logic extMode = optWord_ff[`TMR_BIT_SRC];
  wire logic edgeFall = optWord_ff[`TMR_BIT_EDGE];
  wire logic psaWdt = optWord_ff[`TMR_BIT_PSA];
  wire logic [2:0] rateSel = optWord_ff[`TMR_RATE_HI:`TMR_RATE_LO];

  // Strobes decoded from the core, the phase and the watchdog input
  wire logic timerWr = fileWrEn && (fileAddr == `TMR_ADDR_COUNT);
  wire logic sampleEn = (phase_ff == TMR_PH_Q2) || (phase_ff == TMR_PH_Q4);
  wire logic wdtTick = wdtSync2_ff ^ wdtLast_ff;

  // Count source and prescaler routing
  wire logic timerSrcTick = extMode ? extEdge_ff : instrTick;
  wire logic preSrcTick = psaWdt ? wdtTick : timerSrcTick;
  wire logic [PRE_W-1:0] preMask = rateMask(rateSel, psaWdt);
  wire logic preFull = ((prescale_ff & preMask) == preMask);
  wire logic timerGated = psaWdt ? timerSrcTick : (timerSrcTick && preFull);
  wire logic timerInc = timerGated && (inhibit_ff == 2'h0);
  wire logic preClear = (timerWr && !psaWdt) || (wdtClearOp && psaWdt);

  // Phase generator: one instruction cycle is four clocks
  always_comb begin
    unique case (phase_ff)
      TMR_PH_Q1: nxt_phase = TMR_PH_Q2;
      TMR_PH_Q2: nxt_phase = TMR_PH_Q3;
      TMR_PH_Q3: nxt_phase = TMR_PH_Q4;
      TMR_PH_Q4: nxt_phase = TMR_PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= TMR_PH_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign instrTick = (phase_ff == TMR_PH_Q4);

  // Control word and direction register loads
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      optWord_ff <= `TMR_OPT_RESET;
      dirCtl_ff <= `TMR_DIR_RESET;
    end else begin
      if (optLoad) begin
        optWord_ff <= workReg;
      end
      if (dirLoad) begin
        dirCtl_ff <= workReg[3:0];
      end
    end
  end

  // Pin control outputs
  assign pinDirEff = extMode ? (dirCtl_ff | 4'h4) : dirCtl_ff;
  assign wakeEnable = {dirCtl_ff[3], dirCtl_ff[1:0]} & {3{~wakeDisable}};
  assign pullupEnable = {dirCtl_ff[3], dirCtl_ff[1:0]} & {3{~pullDisable}};

  // External input: two-flop synchroniser, then phase sampling
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extSync1_ff <= 1'b0;
      extSync2_ff <= 1'b0;
      pinSample_ff <= 1'b0;
      extEdge_ff <= 1'b0;
    end else begin
      extSync1_ff <= extCountIn;
      extSync2_ff <= extSync1_ff;
      extEdge_ff <= 1'b0;
      if (sampleEn) begin
        pinSample_ff <= extSync2_ff;
        extEdge_ff <= edgeFall ? (pinSample_ff && !extSync2_ff) : (!pinSample_ff && extSync2_ff);
      end
    end
  end

  // Watchdog tick arrives from another oscillator
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdtSync1_ff <= 1'b0;
      wdtSync2_ff <= 1'b0;
      wdtLast_ff <= 1'b0;
    end else begin
      wdtSync1_ff <= wdtTickIn;
      wdtSync2_ff <= wdtSync1_ff;
      wdtLast_ff <= wdtSync2_ff;
    end
  end

  assign wdtPostTick = psaWdt ? (wdtTick && preFull) : wdtTick;

  // Prescaler next value: clear beats count
  always_comb begin
    nxt_prescale = prescale_ff;
    if (preClear) begin
      nxt_prescale = '0;
    end else if (preSrcTick) begin
      nxt_prescale = prescale_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_ff <= '0;
    end else begin
      prescale_ff <= nxt_prescale;
    end
  end

  // Write inhibit counts down on instruction cycles
  always_comb begin
    nxt_inhibit = inhibit_ff;
    if (timerWr) begin
      nxt_inhibit = `TMR_INHIBIT_CYC;
    end else if (instrTick && (inhibit_ff != 2'h0)) begin
      nxt_inhibit = inhibit_ff - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inhibit_ff <= 2'h0;
    end else begin
      inhibit_ff <= nxt_inhibit;
    end
  end

  // Timer count: a write wins over an increment
  always_comb begin
    nxt_timerCount = timerCount_ff;
    if (timerWr) begin
      nxt_timerCount = fileWrData;
    end else if (timerInc) begin
      nxt_timerCount = timerCount_ff + 8'h01;
    end
  end

  // No reset here so the count keeps its value over resets
  always_ff @(posedge clk) begin
    timerCount_ff <= nxt_timerCount;
  end

  assign timerValue = timerCount_ff;

  // Helper for the edge delay check; measured from the synchronised edge,
  // so the synchroniser lag is taken off the pin-to-count window
  localparam int EXT_DLY_LO = `TMR_EXT_DLY_MIN_CYC - 1;
  localparam int EXT_DLY_HI = `TMR_EXT_DLY_MAX_CYC - 2;
  logic syncLast_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncLast_ff <= 1'b0;
    end else begin
      syncLast_ff <= extSync2_ff;
    end
  end
  wire logic syncEdge = edgeFall ? (syncLast_ff && !extSync2_ff) : (!syncLast_ff && extSync2_ff);

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_instr_rate: assert property (
    (!extMode && psaWdt && instrTick && inhibit_ff == 2'h0 && !timerWr)
      |=> (timerCount_ff == $past(timerCount_ff) + 8'h01)
  ) else $error("timer missed an instruction-cycle increment");

  chk_instr_quiet: assert property (
    (!extMode && !instrTick && !timerWr) |=> $stable(timerCount_ff)
  ) else $error("timer moved between instruction cycles");

  chk_write_inhibit: assert property (
    (timerWr ##1 (!timerWr)[*5]) |-> (timerCount_ff == $past(fileWrData, 5))
  ) else $error("timer counted too soon after a write");

  chk_inhibit_len: assert property (
    (timerWr ##1 (!timerWr && !instrTick)[*3] ##1 (!timerWr && instrTick)
      ##1 (!timerWr && !instrTick)[*3] ##1 (!timerWr && instrTick)) |=> (inhibit_ff == 2'h0)
  ) else $error("write inhibit lasted other than two cycles");

  chk_ext_count: assert property (
    (extMode && psaWdt && extEdge_ff && inhibit_ff == 2'h0 && !timerWr)
      |=> (timerCount_ff == $past(timerCount_ff) + 8'h01)
  ) else $error("counter missed an external edge");

  chk_edge_polarity: assert property (
    extEdge_ff |-> (pinSample_ff == !$past(edgeFall))
  ) else $error("counted the wrong external edge");

  chk_pin_input: assert property (
    extMode |-> pinDirEff[`TMR_PIN_COUNT]
  ) else $error("external count pin not held as input");

  chk_wdt_unscaled: assert property (
    (!psaWdt && wdtTick) |-> wdtPostTick
  ) else $error("watchdog tick lost without prescaler");

  chk_rate_timer: assert property (
    (timerInc && !psaWdt) |-> (&(prescale_ff | (8'hFE << rateSel)))
  ) else $error("timer prescale ratio wrong");

  chk_pre_timer_clr: assert property (
    (timerWr && !psaWdt) |=> (prescale_ff == '0)
  ) else $error("timer write failed to clear prescaler");

  chk_pre_wdt_clr: assert property (
    (wdtClearOp && psaWdt) |=> (prescale_ff == '0)
  ) else $error("watchdog clear failed to clear prescaler");

  chk_reset_values: assert property (
    $rose(reset_n) |-> (optWord_ff == `TMR_OPT_RESET && prescale_ff == '0)
  ) else $error("reset values wrong");

  chk_opt_pins: assert property (
    (optLoad && !dirLoad) |=> (pullupEnable == ({dirCtl_ff[3], dirCtl_ff[1:0]} & {3{~$past(workReg[6])}}))
  ) else $error("pull-up enables disagree with control word");

  chk_wrap: assert property (
    (timerCount_ff == 8'hFF && timerInc && !timerWr) |=> (timerCount_ff == 8'h00)
  ) else $error("timer failed to wrap");

  chk_ext_delay: assert property (
    (extMode && psaWdt && syncEdge && inhibit_ff == 2'h0 && !timerWr && !optLoad)
      |-> ##[EXT_DLY_LO:EXT_DLY_HI] ($changed(timerCount_ff) || timerWr)
  ) else $error("external edge not counted within delay window");

  chk_tick_spacing: assert property (
    instrTick |=> ((!instrTick)[*3] ##1 instrTick)
  ) else $error("instruction cycle is not four clocks");

  chk_pre_count: assert property (
    (preSrcTick && !preClear) |=> (prescale_ff == $past(prescale_ff) + 8'h01)
  ) else $error("prescaler missed a count");

  chk_ctl_hold: assert property (
    (!optLoad) |=> $stable(optWord_ff)
  ) else $error("control word changed without a load");

  chk_wake_load: assert property (
    (optLoad && !dirLoad) |=> (wakeEnable == ({dirCtl_ff[3], dirCtl_ff[1:0]} & {3{~$past(workReg[7])}}))
  ) else $error("wake enables disagree with control word");

  chk_dir_override: assert property (
    (dirLoad && !optLoad) |=> (pullupEnable == ($past({workReg[3], workReg[1:0]}) & {3{~pullDisable}}))
  ) else $error("direction bits failed to override pull-ups");

  cov_ext_inc: cover property (extMode && timerInc);
  cov_wdt_clear: cover property (psaWdt && wdtClearOp);
  cov_pre_timer: cover property (!psaWdt && timerInc && rateSel == 3'h7);
  cov_wdt_post: cover property (psaWdt && wdtPostTick);
  cov_wrap: cover property (timerCount_ff == 8'hFF && timerInc);

endmodule // tmr_timer8

/* bench/tmr_pin_model.sv */
// Model of whatever drives the external count pin of the timer.
// Assumes the bench asks for a level and clk is the oscillator clock.
`timescale 1ns/1ps

module tmr_pin_model (
  // Clock
  input wire logic clk,
  // Level asked for by the bench
  input wire logic wantLevel,
  // Count pin
  output logic pinOut
);
  int holdCnt;

  initial begin
    pinOut = 1'b0;
    holdCnt = 0;
  end

  // Follows the request at a falling edge; each level is held long enough
  // that the synchroniser cannot miss it
  always @(negedge clk) begin
    if (wantLevel !== pinOut && holdCnt >= 2) begin
      pinOut <= wantLevel;
      holdCnt <= 0;
    end else begin
      holdCnt <= holdCnt + 1;
    end
  end
endmodule // tmr_pin_model

/* bench/test_timer8_with_shared_prescaler.sv */
// Self-checking bench for the 8-bit timer with shared prescaler.
// Assumes tmr_timer8 and tmr_pin_model; inputs change at falling edges.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module test_timer8_with_shared_prescaler;
  import tmr_pkg::*;
  logic clk, reset_n, fileWrEn, optLoad, dirLoad, wdtClearOp, wdtTickIn, wantLevel;
  logic wdtPostTick, extCountIn, instrTick;
  tmr_byte_t fileAddr, fileWrData, workReg, timerValue, v0;
  tmr_dir_t pinDirEff;
  tmr_pins3_t wakeEnable, pullupEnable;
  int num_errors, checks_done, wdtPulses, m;

  tmr_timer8 #(.PRE_W(8)) i_tmr_timer8 (.clk(clk), .reset_n(reset_n), .fileWrEn(fileWrEn),
    .fileAddr(fileAddr), .fileWrData(fileWrData), .optLoad(optLoad), .dirLoad(dirLoad),
    .workReg(workReg), .wdtClearOp(wdtClearOp), .wdtTickIn(wdtTickIn), .wdtPostTick(wdtPostTick),
    .extCountIn(extCountIn), .timerValue(timerValue), .instrTick(instrTick),
    .pinDirEff(pinDirEff), .wakeEnable(wakeEnable), .pullupEnable(pullupEnable));
  tmr_pin_model i_tmr_pin_model (.clk(clk), .wantLevel(wantLevel), .pinOut(extCountIn));

  // Oscillator clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts watchdog pulses leaving the postscaler
  always @(negedge clk) begin
    if (wdtPostTick === 1'b1) wdtPulses++;
  end

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // One-clock strobe: 0 timer write, 1 control load, 2 direction load, 3 watchdog clear
  task automatic pulse(input int kind, input tmr_byte_t w);
    @(negedge clk);
    workReg = w;
    fileWrData = w;
    fileWrEn = (kind == 0);
    optLoad = (kind == 1);
    dirLoad = (kind == 2);
    wdtClearOp = (kind == 3);
    @(negedge clk);
    {fileWrEn, optLoad, dirLoad, wdtClearOp} = 4'h0;
  endtask

  // Returns just after the next instruction-cycle edge
  task automatic wait_tick();
    int n;
    n = 0;
    while (instrTick !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask

  task automatic count_ticks(output int k);
    tmr_byte_t s;
    s = timerValue;
    k = 0;
    while (timerValue === s && k < 600) begin
      wait_tick();
      k++;
    end
  endtask

  task automatic wdt_toggles(input int cnt);
    repeat (cnt) begin
      @(negedge clk);
      wdtTickIn = ~wdtTickIn;
      repeat (8) @(negedge clk);
    end
  endtask

  // Moves the pin, then counts clocks until the timer changes (12 = none)
  task automatic ext_edge(input logic lvl, output int n);
    @(negedge clk);
    wantLevel = lvl;
    v0 = timerValue;
    wait (extCountIn === lvl);
    n = 0;
    while (timerValue === v0 && n < 12) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic t_pins();
    check(pinDirEff === `TMR_DIR_RESET && wakeEnable === 3'h0 && pullupEnable === 3'h0, "reset pins");
    pulse(0, 8'h00);
    pulse(1, 8'h48);
    check(wakeEnable === 3'h7 && pullupEnable === 3'h0, "pullup bit");
    pulse(1, 8'h88);
    check(wakeEnable === 3'h0 && pullupEnable === 3'h7, "wake bit");
    pulse(2, 8'h00);
    check(wakeEnable === 3'h0 && pullupEnable === 3'h0, "direction override");
    pulse(2, 8'h0F);
  endtask

  task automatic t_count();
    pulse(1, 8'h08);
    pulse(0, 8'hFE);
    check(timerValue === 8'hFE, "write value");
    wait_tick();
    wait_tick();
    check(timerValue === 8'hFE, "inhibit after write");
    wait_tick();
    check(timerValue === 8'hFF, "one per cycle");
    wait_tick();
    check(timerValue === 8'h00, "wrap");
  endtask

  task automatic t_prescale();
    int k;
    for (int n = 0; n < 8; n++) begin
      pulse(1, tmr_byte_t'(n));
      pulse(0, 8'h00);
      count_ticks(k);
      if (n > 0) check(k == (2 << n), "write clears prescaler");
      count_ticks(k);
      check(k == (2 << n), "timer ratio");
    end
  endtask

  task automatic t_wdt();
    pulse(3, 8'h00);
    pulse(0, 8'h00);
    pulse(1, 8'h0A);
    pulse(3, 8'h00);
    wdtPulses = 0;
    repeat (4) begin
      wdt_toggles(2);
      pulse(3, 8'h00);
    end
    check(wdtPulses == 0, "clear resets postscaler");
    wdtPulses = 0;
    wdt_toggles(8);
    check(wdtPulses == 2, "watchdog ratio");
    pulse(1, 8'h02);
    wdtPulses = 0;
    wdt_toggles(3);
    check(wdtPulses == 3, "watchdog without prescaler");
  endtask

  task automatic t_ext();
    tmr_byte_t s;
    for (int e = 0; e < 2; e++) begin
      pulse(1, 8'h28 | tmr_byte_t'(e << 4));
      pulse(2, 8'h00);
      check(pinDirEff[2] === 1'b1, "count pin input");
      s = timerValue;
      for (int i = 0; i < 3; i++) begin
        ext_edge(e[0], m);
        check(m == 12, "wrong edge counted");
        ext_edge(!e[0], m);
        check(m >= 4 && m <= 7, "edge delay");
      end
      check(timerValue === s + 8'h03, "edge count");
      pulse(2, 8'h0F);
    end
  endtask

  task automatic t_reset2();
    pulse(1, 8'h28);
    check(wakeEnable === 3'h7 && pullupEnable === 3'h7, "control word before reset");
    v0 = timerValue;
    fileAddr = 8'h02;
    pulse(0, 8'h55);
    check(timerValue === v0, "other address ignored");
    fileAddr = `TMR_ADDR_COUNT;
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    check(wakeEnable === 3'h0 && pullupEnable === 3'h0, "control word after reset");
    check(timerValue === v0, "count kept over reset");
    repeat (2) @(negedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    {reset_n, fileWrEn, optLoad, dirLoad, wdtClearOp, wdtTickIn, wantLevel} = 7'h0;
    {fileAddr, fileWrData, workReg} = {`TMR_ADDR_COUNT, 8'h00, 8'h00};
    {num_errors, checks_done, wdtPulses} = 0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    t_pins();
    t_count();
    t_prescale();
    t_wdt();
    t_ext();
    t_reset2();
    finish_test();
  end
endmodule // test_timer8_with_shared_prescaler
